// file: hw/mdio_ext_pkg.sv
package mdio_ext_pkg;

   // ------------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------------
   localparam logic [5:0] PRE_ONES     = 6'h20;
   localparam logic [1:0] OP_READ      = 2'h2;
   localparam logic [1:0] OP_WRITE     = 2'h1;
   localparam logic [4:0] OP_LAST      = 5'h01;
   localparam logic [4:0] FIELD_LAST   = 5'h04;
   localparam logic [4:0] DATA_LAST    = 5'h0F;
   localparam int         PHY_EXT_BIT  = 4;
   localparam int         HALF_BIT     = 0;
   localparam int         HALF_W       = 16;
   localparam int         WORD_W       = 32;
   localparam int         DADDR_W      = 8;

   // ------------------------------------------------------------------
   // Mode strap and synchroniser settling
   // ------------------------------------------------------------------
   localparam logic [1:0] MODE_EXT     = 2'h1;
   localparam logic [1:0] STRAP_TAKE   = 2'h2;
   localparam logic [1:0] STRAP_DONE   = 2'h3;

   // ------------------------------------------------------------------
   // Internal register space carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic               strobe;
      logic [DADDR_W-1:0] addr;
   } addr_evt_s;

   typedef struct packed {
      logic               hit;
      logic               half_only;
      logic [WORD_W-1:0]  data;
   } rd_rsp_s;

   typedef struct packed {
      logic               strobe;
      logic [DADDR_W-1:0] addr;
      logic [WORD_W-1:0]  data;
   } wr_req_s;

   typedef enum logic [1:0] {
      RD_FIRST,
      RD_SECOND,
      RD_INVALID
   } rd_kind_e;

endpackage

// file: hw/sync_cell.sv
`timescale 1ns/10ps
`default_nettype none

module sync_cell #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

`default_nettype wire

// file: hw/rise_detect.sv
`timescale 1ns/10ps
`default_nettype none

module rise_detect (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic level,
   output wire logic rise
);

   logic last_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_q <= 1'b0;
      end else begin
         last_q <= level;
      end
   end

   assign rise = level & ~last_q;

endmodule

`default_nettype wire

// file: hw/extended_mdio_register_slave.sv
// Functional notes
// RL1: Claim only frames with PHY address 16..31.
// RL2: Enable only when mode strap reads 01.
// RL3: PHY bits 3:0 and register field form address; code uses register bits 4:1 only, bit 0 picks the half.
// RL4: Register bit 0 picks upper or lower half.
// RL5: Two opposite halves form one 32-bit access.
// RL6: Host sends both halves back to back.
// RL7: Sample and launch MDIO on MDC rising edge.
// RL8: MDIO released except while returning read data.
// RL9: Host sends preamble, start, opcode, addresses.
// RL10: Read: Z, drive low, 16 bits, release.
// RL11: Host drives write turnaround then 16 bits.
// RL12: Same-half second read resets pairing, no error.
// RL13: 16-bit readable registers complete with one read.
// RL14: Capture register value at start of read.
// RL15: Read side effects only after completed pair.
// RL16: Snapshot full word at first read, hold.
// RL17: Unused addresses read back as zeros.
// RL18: Host polls test register after reset.
// RL19: Reset between halves starts a fresh pair.
// RL20: MDIO released throughout a write frame.
// RL21: Same-half second write is discarded.
// RL22: Host never writes unused addresses.
// RL23: Frames with PHY bit 4 clear ignored.
`timescale 1ns/10ps
`default_nettype none

module extended_mdio_register_slave (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     mdc,
   input  wire logic                     mdio_i,
   output var  logic                     mdio_o,
   output var  logic                     mdio_oe,
   input  wire logic [1:0]               mode_strap,
   output var  mdio_ext_pkg::addr_evt_s  rd_req,
   input  wire mdio_ext_pkg::rd_rsp_s    rd_rsp,
   output var  mdio_ext_pkg::addr_evt_s  rd_commit,
   output var  mdio_ext_pkg::wr_req_s    wr_req
);
   import mdio_ext_pkg::*;

   // ------------------------------------------------------------------
   // Pin synchronisers and MDC edge
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_PRE,
      ST_START,
      ST_OP,
      ST_PHY,
      ST_REG,
      ST_TA_Z,
      ST_TA_DRV,
      ST_RD,
      ST_RD_END,
      ST_TA_WR1,
      ST_TA_WR2,
      ST_WR
   } frame_e;

   logic [1:0]         pins_s;
   logic [1:0]         strap_s;
   logic               mdc_s;
   logic               mdio_s;
   logic               mdc_rise;

   sync_cell #(.WIDTH(2)) u_pin_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({mdc, mdio_i}),
      .sync_out (pins_s)
   );

   sync_cell #(.WIDTH(2)) u_strap_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (mode_strap),
      .sync_out (strap_s)
   );

   assign mdc_s  = pins_s[1];
   assign mdio_s = pins_s[0];

   rise_detect u_mdc_rise (
      .clk   (clk),
      .rst_n (rst_n),
      .level (mdc_s),
      .rise  (mdc_rise)
   );

   // ------------------------------------------------------------------
   // Mode strap capture
   // ------------------------------------------------------------------
   // The strap is taken once, a few cycles after reset release, so that
   // the synchroniser has filled with the real pin level.
   logic [1:0] settle_q;
   logic       ext_en_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_q <= 2'h0;
         ext_en_q <= 1'b0;
      end else if (settle_q != STRAP_DONE) begin
         settle_q <= settle_q + 2'h1;
         if (settle_q == STRAP_TAKE) begin
            ext_en_q <= (strap_s == MODE_EXT); // [RL2]
         end
      end
   end

   // ------------------------------------------------------------------
   // Frame receiver and MDIO driver
   // ------------------------------------------------------------------
   frame_e             state_q;
   logic [5:0]         ones_q;
   logic [4:0]         cnt_q;
   logic [1:0]         op_q;
   logic [4:0]         phy_q;
   logic [4:0]         reg_q;
   logic [HALF_W-1:0]  sh_q;
   logic [4:0]         reg_nx;
   logic               claim;
   logic               rd_start_q;
   logic               rd_done_q;
   logic               wr_done_q;
   logic [DADDR_W-1:0] fr_addr_q;
   logic               fr_half_q;
   logic [WORD_W-1:0]  snap_q;

   assign reg_nx = {reg_q[3:0], mdio_s};
   assign claim  = ext_en_q & phy_q[PHY_EXT_BIT]; // [RL1] [RL2] [RL23]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_PRE;
         ones_q  <= 6'h00;
         cnt_q   <= 5'h00;
         op_q    <= 2'h0;
         phy_q   <= 5'h00;
         reg_q   <= 5'h00;
         sh_q    <= '0;
         mdio_o  <= 1'b0;
         mdio_oe <= 1'b0;
      end else if (mdc_rise) begin // [RL7]
         case (state_q)
            ST_PRE: begin
               if (mdio_s) begin
                  ones_q <= (ones_q == PRE_ONES) ? ones_q : ones_q + 6'h01;
               end else begin
                  ones_q <= 6'h00;
                  if (ones_q == PRE_ONES) begin
                     state_q <= ST_START;
                  end
               end
            end
            ST_START: begin
               cnt_q   <= 5'h00;
               state_q <= mdio_s ? ST_OP : ST_PRE;
            end
            ST_OP: begin
               op_q  <= {op_q[0], mdio_s};
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == OP_LAST) begin
                  cnt_q   <= 5'h00;
                  state_q <= ST_PHY;
               end
            end
            ST_PHY: begin
               phy_q <= {phy_q[3:0], mdio_s};
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == FIELD_LAST) begin
                  cnt_q   <= 5'h00;
                  state_q <= ST_REG;
               end
            end
            ST_REG: begin
               reg_q <= reg_nx;
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == FIELD_LAST) begin
                  cnt_q <= 5'h00;
                  if (claim && op_q == OP_READ) begin
                     state_q <= ST_TA_Z;
                  end else if (claim && op_q == OP_WRITE) begin
                     state_q <= ST_TA_WR1;
                  end else begin
                     state_q <= ST_PRE; // [RL23]
                  end
               end
            end
            ST_TA_Z: begin
               state_q <= ST_TA_DRV; // [RL10]
            end
            ST_TA_DRV: begin
               mdio_oe <= 1'b1; // [RL10]
               mdio_o  <= 1'b0;
               sh_q    <= fr_half_q ? snap_q[WORD_W-1:HALF_W] : snap_q[HALF_W-1:0]; // [RL4]
               cnt_q   <= 5'h00;
               state_q <= ST_RD;
            end
            ST_RD: begin
               mdio_o <= sh_q[HALF_W-1];
               sh_q   <= {sh_q[HALF_W-2:0], 1'b0};
               cnt_q  <= cnt_q + 5'h01;
               if (cnt_q == DATA_LAST) begin
                  state_q <= ST_RD_END;
               end
            end
            ST_RD_END: begin
               mdio_oe <= 1'b0; // [RL8] [RL10]
               mdio_o  <= 1'b0;
               ones_q  <= 6'h00;
               state_q <= ST_PRE;
            end
            ST_TA_WR1: begin
               state_q <= ST_TA_WR2; // [RL20]
            end
            ST_TA_WR2: begin
               cnt_q   <= 5'h00;
               state_q <= ST_WR;
            end
            ST_WR: begin
               sh_q  <= {sh_q[HALF_W-2:0], mdio_s};
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == DATA_LAST) begin
                  ones_q  <= 6'h00;
                  state_q <= ST_PRE;
               end
            end
            default: begin
               mdio_oe <= 1'b0;
               state_q <= ST_PRE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Frame events
   // ------------------------------------------------------------------
   // One-cycle pulses that hand each finished frame phase to the pairing
   // logic; the frame address stays put until the next claimed frame.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_start_q <= 1'b0;
         rd_done_q  <= 1'b0;
         wr_done_q  <= 1'b0;
         fr_addr_q  <= '0;
         fr_half_q  <= 1'b0;
      end else begin
         rd_start_q <= 1'b0;
         rd_done_q  <= 1'b0;
         wr_done_q  <= 1'b0;
         if (mdc_rise && state_q == ST_REG && cnt_q == FIELD_LAST && claim) begin
            fr_addr_q  <= {phy_q[3:0], reg_nx[4:1]}; // [RL3]
            fr_half_q  <= reg_nx[HALF_BIT]; // [RL4]
            rd_start_q <= (op_q == OP_READ);
         end
         if (mdc_rise && state_q == ST_RD_END) begin
            rd_done_q <= 1'b1;
         end
         if (mdc_rise && state_q == ST_WR && cnt_q == DATA_LAST) begin
            wr_done_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Read pairing and snapshot
   // ------------------------------------------------------------------
   logic               rd_pend_q;
   logic [DADDR_W-1:0] rd_pend_addr_q;
   logic               rd_pend_half_q;
   logic               rd_wait_q;
   logic               snap16_q;
   rd_kind_e           rd_kind_q;
   logic               rd_match;

   assign rd_match = rd_pend_q && (fr_addr_q == rd_pend_addr_q);

   // The whole word is captured on the first half and served from the
   // snapshot on the second, so a counter cannot tear between halves.
   // Pairing state lives only in this domain's reset, so a pair cut by
   // reset is never waited for.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend_q      <= 1'b0; // [RL19]
         rd_pend_addr_q <= '0;
         rd_pend_half_q <= 1'b0;
         rd_wait_q      <= 1'b0;
         snap_q         <= '0;
         snap16_q       <= 1'b0;
         rd_kind_q      <= RD_FIRST;
         rd_req         <= '0;
         rd_commit      <= '0;
      end else begin
         rd_req.strobe    <= 1'b0;
         rd_commit.strobe <= 1'b0;
         rd_wait_q        <= rd_req.strobe;
         if (rd_wait_q) begin
            snap_q   <= rd_rsp.hit ? rd_rsp.data : '0; // [RL14] [RL16] [RL17]
            snap16_q <= rd_rsp.half_only;
         end
         if (rd_start_q) begin
            if (rd_match && fr_half_q != rd_pend_half_q) begin
               rd_kind_q <= RD_SECOND; // [RL5] [RL16]
            end else begin
               rd_req.strobe <= 1'b1; // [RL14]
               rd_req.addr   <= fr_addr_q;
               rd_pend_q     <= 1'b0;
               rd_kind_q     <= (rd_match ? RD_INVALID : RD_FIRST); // [RL12]
            end
         end
         if (rd_done_q) begin
            case (rd_kind_q)
               RD_SECOND: begin
                  rd_commit.strobe <= 1'b1; // [RL15]
                  rd_commit.addr   <= fr_addr_q;
                  rd_pend_q        <= 1'b0;
               end
               RD_FIRST: begin
                  if (snap16_q) begin
                     rd_commit.strobe <= 1'b1; // [RL13]
                     rd_commit.addr   <= fr_addr_q;
                  end else begin
                     rd_pend_q      <= 1'b1; // [RL15]
                     rd_pend_addr_q <= fr_addr_q;
                     rd_pend_half_q <= fr_half_q;
                  end
               end
               default: begin
                  rd_pend_q <= 1'b0; // [RL12]
               end
            endcase
         end
         if (wr_done_q) begin
            rd_pend_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Write pairing
   // ------------------------------------------------------------------
   logic               wr_pend_q;
   logic [DADDR_W-1:0] wr_pend_addr_q;
   logic               wr_pend_half_q;
   logic [HALF_W-1:0]  wr_hold_q;
   logic               wr_match;

   assign wr_match = wr_pend_q && (fr_addr_q == wr_pend_addr_q);

   // A half without its partner never reaches the register space.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_q      <= 1'b0;
         wr_pend_addr_q <= '0;
         wr_pend_half_q <= 1'b0;
         wr_hold_q      <= '0;
         wr_req         <= '0;
      end else begin
         wr_req.strobe <= 1'b0;
         if (wr_done_q) begin
            if (wr_match && fr_half_q != wr_pend_half_q) begin
               wr_req.strobe <= 1'b1; // [RL5]
               wr_req.addr   <= fr_addr_q;
               wr_req.data   <= fr_half_q ? {sh_q, wr_hold_q} : {wr_hold_q, sh_q}; // [RL4]
               wr_pend_q     <= 1'b0;
            end else if (wr_match) begin
               wr_pend_q <= 1'b0; // [RL21]
            end else begin
               wr_pend_q      <= 1'b1;
               wr_pend_addr_q <= fr_addr_q;
               wr_pend_half_q <= fr_half_q;
               wr_hold_q      <= sh_q;
            end
         end
         if (rd_start_q) begin
            wr_pend_q <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// file: verification/mdio_host.sv
`timescale 1ns/10ps
`default_nettype none

module mdio_host (
   input  wire logic clk,
   input  wire logic dev_o,
   input  wire logic dev_oe,
   output var  logic mdc,
   output wire logic line
);
   logic host_oe = 1'b0;
   logic host_bit = 1'b1;

   initial begin
      mdc = 1'b0;
   end

   // A released line floats up to the external pull-up level.
   assign line = dev_oe ? dev_o : (host_oe ? host_bit : 1'b1);

   // ---------------------------------------------------------------
   // One management frame; the clock stands still between frames.
   // ---------------------------------------------------------------
   task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rdat);
      logic [63:0] bits;
      int          last;
      bits = {32'hFFFF_FFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
      last = rd ? -1 : 0;
      rdat = '0;
      for (int i = 63; i >= last; i--) begin
         @(posedge clk);
         mdc <= 1'b0;
         host_oe <= !rd || i > 17;
         host_bit <= (i >= 0) ? bits[i] : 1'b1;
         repeat (6) @(posedge clk);
         rdat = {rdat[14:0], line};
         mdc <= 1'b1;
         repeat (5) @(posedge clk);
      end
      @(posedge clk);
      mdc <= 1'b0;
      host_oe <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule

`default_nettype wire

// file: verification/extended_mdio_register_slave_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module ext_mdio_checker (
   input wire logic                    clk,
   input wire logic                    rst_n,
   input wire logic                    mdc,
   input wire logic                    mdio_i,
   input wire logic                    mdio_o,
   input wire logic                    mdio_oe,
   input wire logic [1:0]              mode_strap,
   input wire mdio_ext_pkg::addr_evt_s rd_req,
   input wire mdio_ext_pkg::rd_rsp_s   rd_rsp,
   input wire mdio_ext_pkg::addr_evt_s rd_commit,
   input wire mdio_ext_pkg::wr_req_s   wr_req
);
   import mdio_ext_pkg::*;
   logic       mdc_q;
   logic [4:0] bits_q;

   // ---------------------------------------------------------------
   // Clock rises counted while the pin is driven
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mdc_q <= 1'b0;
      end else begin
         mdc_q <= mdc;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bits_q <= 5'h00;
      end else if (!mdio_oe) begin
         bits_q <= 5'h00;
      end else if (mdc && !mdc_q) begin
         bits_q <= bits_q + 5'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   rd_pulse_a: assert property (rd_req.strobe |=> !rd_req.strobe)
      else $error("read request longer than one cycle");
   commit_pulse_a: assert property (rd_commit.strobe |=> !rd_commit.strobe)
      else $error("commit longer than one cycle");
   commit_addr_a: assert property (rd_commit.strobe |-> rd_commit.addr == rd_req.addr)
      else $error("commit address differs from read address");
   write_quiet_a: assert property (wr_req.strobe |-> !mdio_oe ##1 !wr_req.strobe)
      else $error("write strobe with pin driven or too long");
   ta_low_a: assert property ($rose(mdio_oe) |-> !mdio_o)
      else $error("turnaround not driven low");
   drive_len_a: assert property ($fell(mdio_oe) |-> bits_q == 5'd17)
      else $error("pin driven for wrong number of clock rises");
   launch_edge_a: assert property ($past(mdio_oe) && $changed(mdio_o) |-> mdc)
      else $error("output changed away from the rising clock");
   strap_gate_a: assert property (mdio_oe || rd_req.strobe |-> mode_strap == MODE_EXT)
      else $error("activity while mode strap disables the block");
   answer_time_a: assert property (rd_req.strobe |-> !mdio_oe ##[15:30] $rose(mdio_oe))
      else $error("read answer not started in time");
endmodule

bind extended_mdio_register_slave ext_mdio_checker u_chk (
   .clk        (clk),
   .rst_n      (rst_n),
   .mdc        (mdc),
   .mdio_i     (mdio_i),
   .mdio_o     (mdio_o),
   .mdio_oe    (mdio_oe),
   .mode_strap (mode_strap),
   .rd_req     (rd_req),
   .rd_rsp     (rd_rsp),
   .rd_commit  (rd_commit),
   .wr_req     (wr_req)
);

`default_nettype wire

// file: verification/extended_mdio_register_slave_bench.sv
`timescale 1ns/10ps
`default_nettype none

module extended_mdio_register_slave_bench;
   import mdio_ext_pkg::*;
   logic        clk;
   logic        rst_n = 1'b0;
   logic [1:0]  mode_strap = MODE_EXT;
   logic        mdc;
   wire logic   mdio_line;
   logic        mdio_o;
   logic        mdio_oe;
   addr_evt_s   rd_req;
   addr_evt_s   rd_commit;
   rd_rsp_s     rd_rsp = '0;
   wr_req_s     wr_req;
   wr_req_s     last_wr;
   logic [31:0] mem [256];
   logic [7:0]  last_req;
   logic [7:0]  last_commit;
   logic [15:0] rd16;
   logic        seen_oe;
   int          fail_count, checks_done, n_req, n_commit, n_wr;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   extended_mdio_register_slave u_dut (.clk(clk), .rst_n(rst_n), .mdc(mdc),
      .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mode_strap(mode_strap),
      .rd_req(rd_req), .rd_rsp(rd_rsp), .rd_commit(rd_commit), .wr_req(wr_req));
   mdio_host u_host (.clk(clk), .dev_o(mdio_o), .dev_oe(mdio_oe), .mdc(mdc), .line(mdio_line));

   // ---------------------------------------------------------------
   // Register space model and event monitors
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (rd_req.strobe === 1'b1) begin
         rd_rsp <= '{rd_req.addr < 8'hF0, rd_req.addr == 8'hE5, mem[rd_req.addr]};
         last_req <= rd_req.addr;
         n_req <= n_req + 1;
      end
      if (rd_commit.strobe === 1'b1) begin
         last_commit <= rd_commit.addr;
         n_commit <= n_commit + 1;
      end
      if (wr_req.strobe === 1'b1) begin
         last_wr <= wr_req;
         n_wr <= n_wr + 1;
      end
      if (mdio_oe !== 1'b0) seen_oe <= 1'b1;
   end

   function automatic logic [15:0] half(input logic [31:0] w, input logic s);
      return s ? w[31:16] : w[15:0];
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd(input logic [4:0] p, input logic [4:0] r);
      seen_oe = 1'b0;
      u_host.frame(1'b1, p, r, 16'h0000, rd16);
   endtask

   task automatic wr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
      seen_oe = 1'b0;
      u_host.frame(1'b0, p, r, d, rd16);
   endtask

   task automatic do_reset(input logic [1:0] m);
      @(posedge clk);
      rst_n <= 1'b0;
      mode_strap <= m;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      stop_test();
   end

   initial begin
      int          s, c;
      logic [4:0]  p, r;
      logic [7:0]  a;
      logic [31:0] w;
      s = $urandom(32'h6640C26C);
      foreach (mem[i]) mem[i] = $urandom;
      // Reads are only trusted once reset is over and the strap has settled.
      do_reset(MODE_EXT);
      repeat (6) begin
         p = {1'b1, 4'($urandom % 14)};
         r = 5'($urandom);
         a = {p[3:0], r[4:1]};
         w = mem[a];
         c = n_commit;
         rd(p, r);
         check("req addr", a, last_req);
         check("first half", half(w, r[0]), rd16);
         check("no early commit", c, n_commit);
         mem[a] = $urandom;
         rd(p, r ^ 5'h01);
         check("second half", half(w, !r[0]), rd16);
         check("commit count", c + 1, n_commit);
         check("commit addr", a, last_commit);
      end
      $display("test read pairs done");
      repeat (3) begin
         p = {1'b1, 4'($urandom % 14)};
         r = 5'($urandom);
         w = $urandom;
         c = n_wr;
         wr(p, r, half(w, r[0]));
         wr(p, r ^ 5'h01, half(w, !r[0]));
         check("write count", c + 1, n_wr);
         check("write addr", {p[3:0], r[4:1]}, last_wr.addr);
         check("write data", w, last_wr.data);
         check("quiet write", 0, seen_oe);
      end
      c = n_wr;
      wr(p, r, 16'h1234);
      wr(p, r, 16'h5678);
      check("same half write", c, n_wr);
      $display("test writes done");
      c = n_commit;
      rd(5'h12, 5'h06);
      mem[8'h23] = $urandom;
      w = mem[8'h23];
      rd(5'h12, 5'h06);
      check("fresh same half", half(w, 1'b0), rd16);
      rd(5'h12, 5'h07);
      check("new first half", half(w, 1'b1), rd16);
      mem[8'h23] = $urandom;
      rd(5'h12, 5'h06);
      check("held half", half(w, 1'b0), rd16);
      check("single commit", c + 1, n_commit);
      rd(5'h1F, 5'h00);
      check("unused low", 0, rd16);
      rd(5'h1F, 5'h01);
      check("unused high", 0, rd16);
      c = n_commit;
      rd(5'h1E, 5'h0A);
      check("half only data", half(mem[8'hE5], 1'b0), rd16);
      check("half only commit", c + 1, n_commit);
      $display("test pairing done");
      c = n_req;
      rd(5'h05, 5'h02);
      check("low phy req", c, n_req);
      check("low phy drive", 0, seen_oe);
      check("low phy line", 16'hFFFF, rd16);
      c = n_commit;
      rd(5'h13, 5'h08);
      do_reset(MODE_EXT);
      w = mem[8'h34];
      rd(5'h13, 5'h09);
      check("after reset data", half(w, 1'b1), rd16);
      check("after reset no commit", c, n_commit);
      rd(5'h13, 5'h08);
      check("after reset commit", c + 1, n_commit);
      $display("test ignore and reset done");
      for (int m = 0; m < 4; m++) begin
         if (m != 1) begin
            do_reset(2'(m));
            c = n_req;
            rd(5'h11, 5'h00);
            check("strap req", c, n_req);
            check("strap drive", 0, seen_oe);
         end
      end
      $display("test strap done");
      stop_test();
   end
endmodule

`default_nettype wire
